// ### mfs_pkg.sv
package mfs_pkg;
  localparam int CLK_HZ         = 250_000_000;
  localparam int TICK_MS_NS     = 1_000_000;
  localparam int CYC_PER_MS     = CLK_HZ / 1000;
  localparam int MS_PER_S       = 1000;
  localparam int MEAS_W         = 16;
  localparam int CUR_W          = 16;
  localparam int PCT_W          = 7;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
  localparam int MS_CNT_W       = $clog2(CYC_PER_MS);
  localparam int DRV_HOT_C      = 125;
  localparam logic [MEAS_W-1:0] DRV_HOT_LIM = 16'h007D;

  typedef struct packed {
    logic [MEAS_W-1:0] inCurrent;
    logic [MEAS_W-1:0] inVoltage;
    logic [MEAS_W-1:0] usbCurrent;
    logic [MEAS_W-1:0] usbVoltage;
    logic signed [MEAS_W-1:0] boardTemp;
    logic signed [MEAS_W-1:0] driverTemp;
  } mfs_meas_t;

  typedef struct packed {
    logic [MEAS_W-1:0] maxInCurrent;
    logic [MEAS_W-1:0] maxInVoltage;
    logic [MEAS_W-1:0] maxUsbCurrent;
    logic [MEAS_W-1:0] maxUsbVoltage;
    logic [MEAS_W-1:0] minUsbVoltage;
    logic signed [MEAS_W-1:0] maxBoardTemp;
    logic [MEAS_W-1:0] lowVoltOff;
  } mfs_limits_t;

  typedef struct packed {
    logic lowVoltEn;
    logic tempSensorPresent;
    logic overheatEn;
    logic bridgeAlertEn;
    logic bordMissetEn;
    logic stickyEn;
    logic usbReconnEn;
    logic reduceEn;
    logic powerOffEn;
    logic smoothEn;
  } mfs_opts_t;

  // cause bits, also the reported alarm cause
  typedef struct packed {
    logic inCurrent;
    logic inVoltage;
    logic lowVoltage;
    logic usbCurrent;
    logic usbVoltHigh;
    logic usbVoltLow;
    logic boardTemp;
    logic driverHot;
    logic bridgeAlert;
    logic bordMisset;
  } mfs_cause_t;

  typedef enum logic [1:0] {MFS_RUN, MFS_STOP_FULL, MFS_STOP_HOLD, MFS_STOP_OFF} mfs_pwr_t;
endpackage

// ### mfs_supervisor.sv
`timescale 1ns/100ps
module mfs_supervisor (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire mfs_pkg::mfs_meas_t   meas,
  input  wire mfs_pkg::mfs_limits_t limits,
  input  wire mfs_pkg::mfs_opts_t   opts,
  input  wire logic                 driverAlert,
  input  wire logic                 limitLeft,
  input  wire logic                 limitRight,
  input  wire logic                 movingLeft,
  input  wire logic                 movingRight,
  input  wire logic                 stopCmd,
  input  wire logic                 moveCmd,
  input  wire logic                 usbLinkBroken,
  input  wire logic [15:0]          nominalCurrent,
  input  wire logic [6:0]           holdPercent,
  input  wire logic [15:0]          reduceDelayMs,
  input  wire logic [15:0]          powerOffDelayS,
  input  wire logic [15:0]          currentSetMs,
  output logic                      alarm,
  output mfs_pkg::mfs_cause_t       alarmCause,
  output logic                      powerEnable,
  output logic [15:0]               currentSetpoint,
  output logic                      usbReconnect,
  output mfs_pkg::mfs_pwr_t         powerState
);
  import mfs_pkg::*;

  mfs_cause_t          liveCause;
  mfs_cause_t          next_alarmCause;
  logic                next_alarm;
  mfs_pwr_t            next_powerState;
  logic [MS_CNT_W-1:0] msDiv;
  logic [MS_CNT_W-1:0] next_msDiv;
  logic                msTick;
  logic [9:0]          secDiv;
  logic [9:0]          next_secDiv;
  logic [15:0]         msCount;
  logic [15:0]         next_msCount;
  logic [15:0]         secCount;
  logic [15:0]         next_secCount;
  logic [15:0]         target;
  logic [15:0]         next_currentSetpoint;
  logic [15:0]         rampStep;
  logic                next_usbReconnect;
  logic [22:0]         holdProduct;
  logic [6:0]          holdPct;

  // unsigned compare helper used by several limit checks
  function automatic logic above(input logic [MEAS_W-1:0] v, input logic [MEAS_W-1:0] lim);
    return v > lim;
  endfunction

  always_comb begin
    liveCause             = '0;
    liveCause.inCurrent   = above(meas.inCurrent, limits.maxInCurrent);
    liveCause.inVoltage   = above(meas.inVoltage, limits.maxInVoltage);
    liveCause.lowVoltage  = opts.lowVoltEn && (meas.inVoltage <= limits.lowVoltOff);
    liveCause.usbCurrent  = above(meas.usbCurrent, limits.maxUsbCurrent);
    liveCause.usbVoltHigh = above(meas.usbVoltage, limits.maxUsbVoltage);
    liveCause.usbVoltLow  = meas.usbVoltage < limits.minUsbVoltage;
    liveCause.boardTemp   = opts.tempSensorPresent
                            && (meas.boardTemp > limits.maxBoardTemp);
    liveCause.driverHot   = opts.overheatEn
                            && (meas.driverTemp > $signed(DRV_HOT_LIM));
    liveCause.bridgeAlert = opts.bridgeAlertEn && driverAlert;
    liveCause.bordMisset  = opts.bordMissetEn
                            && ((limitRight && movingLeft) || (limitLeft && movingRight));
  end

  // fault latch: new causes win over the stop clear
  always_comb begin
    if (opts.stickyEn) begin
      next_alarmCause = (stopCmd ? '0 : alarmCause) | liveCause;
    end else begin
      next_alarmCause = liveCause;
    end
    next_alarm = |next_alarmCause;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      alarmCause <= '0;
      alarm      <= 1'b0;
    end else begin
      alarmCause <= next_alarmCause;
      alarm      <= next_alarm;
    end
  end

  // millisecond and second enables from one divider chain
  always_comb begin
    msTick      = (msDiv == MS_CNT_W'(CYC_PER_MS - 1));
    next_msDiv  = msTick ? '0 : msDiv + 1'b1;
    next_secDiv = secDiv;
    if (msTick) begin
      next_secDiv = (secDiv == 10'(MS_PER_S - 1)) ? '0 : secDiv + 1'b1;
    end
  end

  // stop-state sequencing
  always_comb begin
    next_powerState = powerState;
    next_msCount    = msCount;
    next_secCount   = secCount;
    if (moveCmd && !alarm) begin
      next_powerState = MFS_RUN;
      next_msCount    = '0;
      next_secCount   = '0;
    end else if (stopCmd && powerState == MFS_RUN) begin
      next_powerState = MFS_STOP_FULL;
      next_msCount    = '0;
      next_secCount   = '0;
    end else if (powerState != MFS_RUN) begin
      if (msTick && msCount != 16'hFFFF) begin
        next_msCount = msCount + 1'b1;
      end
      if (msTick && secDiv == 10'(MS_PER_S - 1) && secCount != 16'hFFFF) begin
        next_secCount = secCount + 1'b1;
      end
      if (opts.powerOffEn && secCount >= powerOffDelayS) begin
        next_powerState = MFS_STOP_OFF;
      end else if (powerState == MFS_STOP_FULL && opts.reduceEn
                   && msCount >= reduceDelayMs) begin
        next_powerState = MFS_STOP_HOLD;
      end
    end
  end

  // target current and ramp
  always_comb begin
    holdPct     = (holdPercent > PCT_FULL) ? PCT_FULL : holdPercent;
    holdProduct = nominalCurrent * holdPct;
    unique case (powerState)
      MFS_RUN, MFS_STOP_FULL: target = nominalCurrent;
      MFS_STOP_HOLD:          target = 16'(holdProduct / 23'(PCT_FULL));
      MFS_STOP_OFF:           target = '0;
    endcase
    // per-ms step so the full nominal span takes the set time
    rampStep    = (currentSetMs == '0) ? 16'hFFFF : nominalCurrent / currentSetMs;
    if (rampStep == '0) begin
      rampStep = 16'h0001;
    end
    next_currentSetpoint = currentSetpoint;
    // a move leaves the stop states, so the old stop target must not be used
    if (moveCmd && !alarm) begin
      next_currentSetpoint = nominalCurrent;
    end else if (!opts.smoothEn) begin
      next_currentSetpoint = target;
    end else if (msTick) begin
      if (currentSetpoint < target) begin
        next_currentSetpoint = (target - currentSetpoint > rampStep)
                               ? currentSetpoint + rampStep : target;
      end else if (currentSetpoint > target) begin
        next_currentSetpoint = (currentSetpoint - target > rampStep)
                               ? currentSetpoint - rampStep : target;
      end
    end
    next_usbReconnect = opts.usbReconnEn && usbLinkBroken;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      msDiv           <= '0;
      secDiv          <= '0;
      msCount         <= '0;
      secCount        <= '0;
      powerState      <= MFS_RUN;
      currentSetpoint <= '0;
      usbReconnect    <= 1'b0;
    end else begin
      msDiv           <= next_msDiv;
      secDiv          <= next_secDiv;
      msCount         <= next_msCount;
      secCount        <= next_secCount;
      powerState      <= next_powerState;
      currentSetpoint <= next_currentSetpoint;
      usbReconnect    <= next_usbReconnect;
    end
  end

  // fault cuts power at once, ahead of any ramp
  assign powerEnable = !alarm && (powerState != MFS_STOP_OFF);
endmodule // mfs_supervisor

// ### mfs_supervisor_props.sv
`timescale 1ns/100ps
module mfs_supervisor_props
  import mfs_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 reset,
  input wire mfs_pkg::mfs_meas_t   meas,
  input wire mfs_pkg::mfs_limits_t limits,
  input wire mfs_pkg::mfs_opts_t   opts,
  input wire logic                 driverAlert,
  input wire logic                 stopCmd,
  input wire logic                 moveCmd,
  input wire logic                 usbLinkBroken,
  input wire logic [15:0]          nominalCurrent,
  input wire logic                 alarm,
  input wire logic                 powerEnable,
  input wire logic                 usbReconnect,
  input wire mfs_pkg::mfs_pwr_t    powerState,
  input wire logic [15:0]          currentSetpoint
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_over_current: assert property (meas.inCurrent > limits.maxInCurrent |=> alarm)
    else $error("no alarm after overcurrent");
  a_alarm_power_off: assert property (alarm |-> !powerEnable)
    else $error("power on during alarm");
  a_low_volt: assert property (opts.lowVoltEn && meas.inVoltage <= limits.lowVoltOff |=> alarm)
    else $error("no alarm at low voltage");
  a_driver_hot: assert property (opts.overheatEn && meas.driverTemp > 16'sh007D |=> alarm)
    else $error("no alarm on driver overheat");
  a_bridge_alert: assert property (opts.bridgeAlertEn && driverAlert |=> alarm)
    else $error("no alarm on bridge alert");
  a_sticky_hold: assert property (opts.stickyEn && alarm && !stopCmd |=> alarm)
    else $error("sticky alarm dropped without stop");
  a_usb_reconnect: assert property (1'h1 |=> usbReconnect == $past(opts.usbReconnEn && usbLinkBroken))
    else $error("link reset does not follow break");
  a_move_restore: assert property (moveCmd && !alarm |=>
    powerState == MFS_RUN && currentSetpoint == $past(nominalCurrent))
    else $error("move did not restore nominal run");
endmodule // mfs_supervisor_props

// ### mfs_plant.sv
`timescale 1ns/100ps
module mfs_plant
  import mfs_pkg::*;
(
  input  wire logic               mclk,
  input  wire mfs_pkg::mfs_meas_t base,
  input  wire logic [15:0]        overload,
  input  wire logic               powerEnable,
  input  wire logic [15:0]        currentSetpoint,
  output mfs_pkg::mfs_meas_t      meas
);
  // winding current collapses once the bridge is off, so a cause can vanish
  always_ff @(posedge mclk) begin
    meas <= base;
    meas.inCurrent <= powerEnable ? currentSetpoint + overload : 16'h0;
  end
endmodule // mfs_plant

// ### tb_mfs_supervisor.sv
`timescale 1ns/100ps
module tb_mfs_supervisor;
  import mfs_pkg::*;
  logic mclk, reset, driverAlert, limitLeft, limitRight, movingLeft, movingRight;
  logic stopCmd, moveCmd, usbLinkBroken, alarm, powerEnable, usbReconnect;
  logic [15:0] nominalCurrent, reduceDelayMs, powerOffDelayS, currentSetMs;
  logic [15:0] overload, currentSetpoint;
  logic [6:0]  holdPercent;
  mfs_meas_t   base, meas;
  mfs_limits_t limits;
  mfs_opts_t   opts;
  mfs_cause_t  alarmCause;
  mfs_pwr_t    powerState;
  int n_mismatch, comparisons;
  int cb[10] = '{8, 6, 5, 4, 3, 2, 1, 0, 0, 7};
  int pct[2] = '{50, 100};
  mfs_supervisor uut (.*);
  mfs_plant plant (.*);
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    step(1);
    s = 1'h0;
  endtask
  task automatic wait_for(mfs_pwr_t st);
    for (int i = 0; i < 1000 && powerState !== st; i++) step(1);
    cmp("powerState", 16'(st), 16'(powerState));
    if (powerState !== st) complete_run();
  endtask
  task automatic setf(int k, logic on);
    case (k)
      0: base.inVoltage = on ? 16'h2EE1 : 16'h2EE0;
      1: base.usbCurrent = on ? 16'h1C3 : 16'h1C2;
      2: base.usbVoltage = on ? 16'h1451 : 16'h1450;
      3: base.usbVoltage = on ? 16'h1067 : 16'h1068;
      4: base.boardTemp = on ? 16'h51 : 16'h50;
      5: base.driverTemp = on ? 16'h7E : 16'h7D;
      6: driverAlert = on;
      7: {limitRight, movingLeft} = {on, on};
      8: {limitLeft, movingRight} = {on, on};
      default: base.inVoltage = on ? 16'h1F40 : 16'h1F41;
    endcase
  endtask
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    {reset, driverAlert, limitLeft, limitRight, movingLeft, movingRight} = 6'h20;
    {stopCmd, moveCmd, usbLinkBroken, overload, reduceDelayMs, powerOffDelayS} = '0;
    {nominalCurrent, currentSetMs, holdPercent} = {16'h100, 16'h0, 7'h32};
    base = '{16'h0, 16'h2000, 16'h100, 16'h1388, 16'h19, 16'h19};
    limits = '{16'h200, 16'h2EE0, 16'h1C2, 16'h1450, 16'h1068, 16'h50, 16'h1F40};
    opts = 10'h3E0;
    step(4);
    reset = 1'h0;
    step(2);
    cmp("alarm", 16'h0, alarm);
    cmp("powerEnable", 16'h1, powerEnable);
    cmp("currentSetpoint", 16'h100, currentSetpoint);
    $display("reset test done");
    for (int k = 0; k < 10; k++) begin
      setf(k, 1'h1);
      step(2);
      cmp("alarm", 16'h1, alarm);
      cmp("powerEnable", 16'h0, powerEnable);
      cmp("alarmCause", 16'(1 << cb[k]), 16'(alarmCause));
      setf(k, 1'h0);
      step(2);
      cmp("alarm", 16'h0, alarm);
    end
    overload = 16'h200;
    step(2);
    cmp("alarm", 16'h1, alarm);
    step(2);
    cmp("alarm", 16'h0, alarm);
    overload = 16'h0;
    $display("fault test done");
    opts.stickyEn = 1'h1;
    setf(6, 1'h1);
    step(2);
    setf(6, 1'h0);
    pulse(moveCmd);
    step(3);
    cmp("alarm", 16'h1, alarm);
    pulse(stopCmd);
    step(2);
    cmp("alarm", 16'h0, alarm);
    opts.stickyEn = 1'h0;
    $display("sticky test done");
    opts.reduceEn = 1'h1;
    foreach (pct[i]) begin
      holdPercent = 7'(pct[i]);
      pulse(moveCmd);
      cmp("currentSetpoint", 16'h100, currentSetpoint);
      pulse(stopCmd);
      wait_for(MFS_STOP_HOLD);
      step(2);
      cmp("currentSetpoint", 16'(256 * pct[i] / 100), currentSetpoint);
    end
    opts.powerOffEn = 1'h1;
    pulse(moveCmd);
    pulse(stopCmd);
    wait_for(MFS_STOP_OFF);
    step(2);
    cmp("currentSetpoint", 16'h0, currentSetpoint);
    pulse(moveCmd);
    cmp("powerState", 16'(MFS_RUN), 16'(powerState));
    $display("power test done");
    opts.usbReconnEn = 1'h1;
    usbLinkBroken = 1'h1;
    step(2);
    cmp("usbReconnect", 16'h1, usbReconnect);
    $display("link test done");
    complete_run();
  end
endmodule // tb_mfs_supervisor
bind mfs_supervisor mfs_supervisor_props u_props (.*);
